// ===== common/adc_cycle_pkg.sv
// shared types and constants of the conversion-cycle controller and its serial readout
package adc_cycle_pkg;

	// output word layout
	localparam int WORD_BITS = 32;
	localparam int EOC_BIT = 31;
	localparam int CODE_W = 30;
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
	localparam logic [CNT_W-1:0] LAST_FALL = 6'h20;
	localparam logic [CNT_W-1:0] EOC_INDEX = 6'h1F;
	localparam logic FILLER_BIT_VALUE = 1'h0;

	// result codes in sub-lsb units, two's complement before the sign flip
	localparam logic [CODE_W-1:0] FS_CODE = 30'h1000_0000;
	localparam logic [CODE_W-1:0] LSB_STEP = 30'h0000_0020;
	localparam logic [CODE_W-1:0] OVER_CODE = FS_CODE + LSB_STEP;
	localparam logic [CODE_W-1:0] UNDER_CODE = 30'h0000_0000 - FS_CODE - LSB_STEP;
	localparam logic [CODE_W-1:0] SIGN_FLIP = 30'h2000_0000;

	// configuration word shifted in on sdi, enable bit first
	typedef struct packed {
		logic enable;
		logic [4:0] chan;
		logic [3:0] oversampling_ratio;
		logic twox;
	} cfg_t;
	localparam int CFG_BITS = $bits(cfg_t);
	localparam logic [3:0] CFG_LAST_RISE = 4'hA;
	localparam logic [3:0] CFG_RISES = 4'hB;
	localparam cfg_t CFG_RESET = '{enable: 1'h0, chan: 5'h00, oversampling_ratio: 4'h3, twox: 1'h0};
	localparam logic [3:0] OSR_KEEP = 4'h0;
	localparam logic [3:0] OSR_MAX_CODE = 4'hF;
	localparam logic [3:0] OSR_MAX_SHIFT = 4'h9;
	localparam logic [3:0] OSR_CODE_BASE = 4'h1;

	// what the front end measures
	typedef enum logic [1:0] {PH_INPUT = 2'h0, PH_ZERO = 2'h1, PH_REF = 2'h2} fe_phase_t;

	// operating cycle
	typedef enum logic [2:0] {ST_CONVERT = 3'h1, ST_SLEEP = 3'h2, ST_OUTPUT = 3'h4} state_t;

	// timing
	localparam int CLK_FREQ_KHZ = 200000;
	localparam real POR_TIME_MS = 0.5;
	localparam int POR_CYCLES_DEF = int'(POR_TIME_MS * CLK_FREQ_KHZ);
	localparam int CONV_CNT_W = 24;
	localparam int CAL_CYCLES_DEF = 64;
	localparam int SAMPLE_CYCLES_OSR64_DEF = 64;
	localparam int SCK_HALF_CYCLES_DEF = 4;

	// synchroniser lanes
	localparam int SYNC_W = 4;
	localparam int SYNC_CS = 3;
	localparam int SYNC_EXT = 2;
	localparam int SYNC_DONE = 1;
	localparam int SYNC_CFG = 0;

endpackage

// ===== hw/adc_cycle_serial_readout.sv
// conversion-cycle controller with 32-bit serial readout of a delta-sigma converter
//
// Overview of operation
// - cycle convert, sleep, data output, then convert again, always in that order
// - after a conversion, sleep for as long as chip select stays high
// - the result is held unchanged in the word register while sleeping
// - chip select low starts output; in 1X mode the word is the fresh result
// - sdo changes on falling sck so the host samples on rising sck
// - output ends after 32 bits or chip select high; both start a conversion
// - after reset an internal power-on hold of 0.5 ms delays the first conversion
// - first conversion uses channel 0 plus, channel 1 minus, ratio 256, 1X
// - offset and full-scale calibration run inside every conversion, timing unchanged
// - modes come from chip select, sck and clock source pins, and the sdi configuration word
// - word: three status bits, 24-bit result msb first, five sub-lsb bits
// - bit 31 is conversion-done, low active; high while converting
// - bit 30 is a filler bit, always low
// - bit 29 is the sign flag, high for zero or positive input
// - bits 29 and 28 both high for overrange, both low for underrange
// - bits 28 to 5 carry the result, bits 4 to 0 extra resolution
// - chip select high keeps sdo released and sck ignored
// - with chip select low, conversion-done falls at once, without sck
// - bit 31 valid before the first rise; bit 0 leaves on the 31st fall
// - the 32nd falling sck drives sdo high, next word's conversion-done
// - over full scale gives +FS plus one lsb, under gives -FS minus one lsb
// - clock source select low takes sck from the host, high drives it
// - chip select high during output aborts it and starts a conversion
// - configuration enable low keeps the previous speed and channel
`timescale 1ns/10ps
`default_nettype none
module adc_cycle_serial_readout
	import adc_cycle_pkg::*;
#(
	parameter int POR_CYCLES = POR_CYCLES_DEF,
	parameter int CAL_CYCLES = CAL_CYCLES_DEF,
	parameter int SAMPLE_CYCLES_OSR64 = SAMPLE_CYCLES_OSR64_DEF,
	parameter int SCK_HALF_CYCLES = SCK_HALF_CYCLES_DEF
)
(
	// system clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// serial link
	input wire logic cs_n_i,
	input wire logic clock_source_select_i,
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe_o,
	input wire logic sdi_i,
	output logic sdo_o,
	output logic sdo_oe_o,
	// status
	output logic busy_o,
	output state_t cycle_state_o,
	// front end
	output fe_phase_t fe_phase_o,
	output logic [4:0] fe_chan_o,
	output logic [3:0] fe_osr_o,
	output logic fe_twox_o,
	input wire logic signed [CODE_W-1:0] fe_sample_i
);
	localparam int POR_W = $clog2(POR_CYCLES + 1);
	localparam int SCK_W = $clog2(SCK_HALF_CYCLES + 1);
	localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYCLES - 1);
	localparam logic [SCK_W-1:0] SCK_HALF_LAST = SCK_W'(SCK_HALF_CYCLES - 1);
	localparam logic [CONV_CNT_W-1:0] CAL_LEN = CONV_CNT_W'(CAL_CYCLES);
	localparam logic [CONV_CNT_W-1:0] CAL_END = CONV_CNT_W'(2 * CAL_CYCLES);
	localparam logic [CONV_CNT_W-1:0] SAMPLE_BASE = CONV_CNT_W'(SAMPLE_CYCLES_OSR64);

	// synchronised pins and link events
	logic [SYNC_W-1:0] sync_d;
	logic [SYNC_W-1:0] sync_q;
	logic cs_high;
	logic int_mode;
	logic done_seen_reg;
	logic cfg_seen_reg;
	logic done_event;
	logic cfg_event;
	logic link_done_tog;
	logic link_cfg_tog;
	cfg_t link_cfg;

	// power-on hold
	logic [POR_W-1:0] por_cnt_reg;
	logic por_done_reg;

	// cycle state
	state_t state_reg;
	state_t state_next;
	logic start_conv;
	logic eoc_n_reg;

	// configuration
	cfg_t active_cfg_reg;
	cfg_t pending_cfg_reg;
	cfg_t pending_cfg_next;
	logic pending_reg;
	cfg_t apply_src;
	logic apply_en;
	logic keep_speed;
	cfg_t active_cfg_next;

	// conversion timing and calibration
	logic [CONV_CNT_W-1:0] conv_cnt_reg;
	logic [CONV_CNT_W-1:0] sample_len;
	logic [CONV_CNT_W-1:0] conv_last_cnt;
	logic [3:0] osr_shift;
	logic converting;
	logic conv_last;
	logic offset_cap;
	logic fs_cap;
	logic signed [CODE_W-1:0] offset_reg;
	logic signed [CODE_W-1:0] fs_reg;

	// result
	logic signed [CODE_W:0] corr;
	logic signed [CODE_W:0] span;
	logic signed [CODE_W:0] neg_span;
	logic over_range;
	logic under_range;
	logic [CODE_W-1:0] code;
	logic [WORD_BITS-1:0] new_word;
	logic [WORD_BITS-1:0] out_word_reg;
	logic [WORD_BITS-1:0] last_word_reg;

	// internal serial clock
	logic [SCK_W-1:0] sck_div_reg;
	logic sck_reg;
	logic [CNT_W-1:0] sck_falls_reg;
	logic sck_run;
	logic sck_half_end;

	assign sync_d = {cs_n_i, clock_source_select_i, link_done_tog, link_cfg_tog};

	bit_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.d_i(sync_d),
		.q_o(sync_q)
	);

	assign cs_high = sync_q[SYNC_CS];
	assign int_mode = sync_q[SYNC_EXT];
	assign done_event = sync_q[SYNC_DONE] ^ done_seen_reg;
	assign cfg_event = sync_q[SYNC_CFG] ^ cfg_seen_reg;

	always_ff @(posedge clock_i or posedge rst_i)
		if (rst_i)
		begin
			done_seen_reg <= 1'h0;
			cfg_seen_reg <= 1'h0;
		end
		else
		begin
			done_seen_reg <= sync_q[SYNC_DONE];
			cfg_seen_reg <= sync_q[SYNC_CFG];
		end

	// power-on hold before the first conversion
	always_ff @(posedge clock_i or posedge rst_i)
		if (rst_i)
		begin
			por_cnt_reg <= '0;
			por_done_reg <= 1'h0;
		end
		else if (!por_done_reg)
		begin
			por_cnt_reg <= por_cnt_reg + POR_W'(1);
			por_done_reg <= (por_cnt_reg == POR_LAST);
		end

	// conversion timing: offset cal, full-scale cal, then input sampling
	assign osr_shift = (active_cfg_reg.oversampling_ratio == OSR_MAX_CODE) ? OSR_MAX_SHIFT
		: active_cfg_reg.oversampling_ratio - OSR_CODE_BASE;
	assign sample_len = (SAMPLE_BASE << osr_shift) >> active_cfg_reg.twox;
	assign conv_last_cnt = CAL_END + sample_len - CONV_CNT_W'(1);
	assign converting = por_done_reg && (state_reg == ST_CONVERT);
	assign conv_last = converting && (conv_cnt_reg == conv_last_cnt);
	assign offset_cap = converting && (conv_cnt_reg == CAL_LEN - CONV_CNT_W'(1));
	assign fs_cap = converting && (conv_cnt_reg == CAL_END - CONV_CNT_W'(1));
	assign fe_phase_o = (conv_cnt_reg < CAL_LEN) ? PH_ZERO
		: ((conv_cnt_reg < CAL_END) ? PH_REF : PH_INPUT);

	always_ff @(posedge clock_i or posedge rst_i)
		if (rst_i)
			conv_cnt_reg <= '0;
		else if (conv_last || !converting)
			conv_cnt_reg <= '0;
		else
			conv_cnt_reg <= conv_cnt_reg + CONV_CNT_W'(1);

	always_ff @(posedge clock_i or posedge rst_i)
		if (rst_i)
		begin
			offset_reg <= '0;
			fs_reg <= '0;
		end
		else
		begin
			if (offset_cap)
				offset_reg <= fe_sample_i;
			if (fs_cap)
				fs_reg <= fe_sample_i;
		end

	// offset-corrected reading, clamped against the measured full scale
	assign corr = {fe_sample_i[CODE_W-1], fe_sample_i} - {offset_reg[CODE_W-1], offset_reg};
	assign span = {fs_reg[CODE_W-1], fs_reg} - {offset_reg[CODE_W-1], offset_reg};
	assign neg_span = -span;
	assign over_range = (corr > span);
	assign under_range = (corr < neg_span);
	assign code = over_range ? OVER_CODE : (under_range ? UNDER_CODE : corr[CODE_W-1:0]);
	// sign flip turns two's complement into offset binary, sign flag high for zero or positive
	assign new_word = {1'h0, FILLER_BIT_VALUE, code ^ SIGN_FLIP};

	always_ff @(posedge clock_i or posedge rst_i)
		if (rst_i)
		begin
			out_word_reg <= '0;
			last_word_reg <= '0;
		end
		else if (conv_last)
		begin
			// 2X mode shows the previous result, 1X the one just made
			out_word_reg <= active_cfg_reg.twox ? last_word_reg : new_word;
			last_word_reg <= new_word;
		end

	// cycle state machine
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_CONVERT:
				if (conv_last)
					state_next = ST_SLEEP;
			ST_SLEEP:
				if (!cs_high)
					state_next = ST_OUTPUT;
			ST_OUTPUT:
				if (cs_high || done_event)
					state_next = ST_CONVERT;
			default:
				state_next = ST_CONVERT;
		endcase
	end

	assign start_conv = (state_reg == ST_OUTPUT) && (state_next == ST_CONVERT);

	always_ff @(posedge clock_i or posedge rst_i)
		if (rst_i)
		begin
			state_reg <= ST_CONVERT;
			eoc_n_reg <= 1'h1;
		end
		else
		begin
			state_reg <= state_next;
			eoc_n_reg <= (state_next == ST_CONVERT);
		end

	// configuration taken from the link, applied when the next conversion starts
	assign apply_src = cfg_event ? link_cfg : pending_cfg_reg;
	assign apply_en = start_conv && (cfg_event || pending_reg) && apply_src.enable;
	assign keep_speed = (apply_src.oversampling_ratio == OSR_KEEP);
	assign pending_cfg_next = cfg_event ? link_cfg : pending_cfg_reg;

	always_comb
	begin
		active_cfg_next = active_cfg_reg;
		if (apply_en)
		begin
			active_cfg_next.chan = apply_src.chan;
			if (!keep_speed)
			begin
				active_cfg_next.oversampling_ratio = apply_src.oversampling_ratio;
				active_cfg_next.twox = apply_src.twox;
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
		if (rst_i)
		begin
			active_cfg_reg <= CFG_RESET;
			pending_cfg_reg <= CFG_RESET;
			pending_reg <= 1'h0;
		end
		else
		begin
			active_cfg_reg <= active_cfg_next;
			pending_cfg_reg <= pending_cfg_next;
			// a new word arriving with the apply is applied at once, so the clear wins
			pending_reg <= cfg_event ? !start_conv : (pending_reg && !start_conv);
		end

	// internal serial clock: 32 pulses per output state, idle low
	assign sck_run = int_mode && (state_reg == ST_OUTPUT) && (sck_falls_reg != LAST_FALL);
	assign sck_half_end = (sck_div_reg == SCK_HALF_LAST);

	always_ff @(posedge clock_i or posedge rst_i)
		if (rst_i)
		begin
			sck_div_reg <= '0;
			sck_reg <= 1'h0;
			sck_falls_reg <= '0;
		end
		else if (!sck_run)
		begin
			sck_div_reg <= '0;
			sck_reg <= 1'h0;
			if (state_reg != ST_OUTPUT)
				sck_falls_reg <= '0;
		end
		else if (sck_half_end)
		begin
			sck_div_reg <= '0;
			sck_reg <= ~sck_reg;
			if (sck_reg)
				sck_falls_reg <= sck_falls_reg + CNT_ONE;
		end
		else
			sck_div_reg <= sck_div_reg + SCK_W'(1);

	// mode decided by the clock source pin alone
	assign sck_o = sck_reg;
	assign sck_oe_o = int_mode;

	serial_link_shifter u_shifter (
		.sck_i(sck_i),
		.rst_i(rst_i),
		.cs_n_i(cs_n_i),
		.sdi_i(sdi_i),
		.sdo_o(sdo_o),
		.sdo_oe_o(sdo_oe_o),
		.eoc_n_i(eoc_n_reg),
		.word_i(out_word_reg),
		.frame_done_tog_o(link_done_tog),
		.cfg_hold_o(link_cfg),
		.cfg_tog_o(link_cfg_tog)
	);

	assign busy_o = eoc_n_reg;
	assign cycle_state_o = state_reg;
	assign fe_chan_o = active_cfg_reg.chan;
	assign fe_osr_o = active_cfg_reg.oversampling_ratio;
	assign fe_twox_o = active_cfg_reg.twox;
endmodule
`default_nettype wire

// ===== hw/bit_sync.sv
// two-flop synchroniser for a group of independent levels
`timescale 1ns/10ps
`default_nettype none
module bit_sync
#(
	parameter int WIDTH = 1
)
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// levels
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] q_reg;

	always_ff @(posedge clock_i or posedge rst_i)
		if (rst_i)
		begin
			meta_reg <= '0;
			q_reg <= '0;
		end
		else
		begin
			meta_reg <= d_i;
			q_reg <= meta_reg;
		end

	assign q_o = q_reg;
endmodule
`default_nettype wire

// ===== hw/serial_link_shifter.sv
// link-domain shifter: word out on sdo at falling sck, configuration in on sdi at rising sck
`timescale 1ns/10ps
`default_nettype none
module serial_link_shifter
	import adc_cycle_pkg::*;
(
	// link clock and frame
	input wire logic sck_i,
	input wire logic rst_i,
	input wire logic cs_n_i,
	// serial pins
	input wire logic sdi_i,
	output logic sdo_o,
	output logic sdo_oe_o,
	// system side; the word is static while a frame runs, the conversion status is live
	input wire logic eoc_n_i,
	input wire logic [WORD_BITS-1:0] word_i,
	output logic frame_done_tog_o,
	output cfg_t cfg_hold_o,
	output logic cfg_tog_o
);
	logic frame_rst;
	logic [CNT_W-1:0] fall_cnt_reg;
	logic [CNT_W-1:0] fall_next;
	logic [CNT_W-1:0] bit_idx;
	logic bit_reg;
	logic at_start;
	logic at_end;
	logic done_tog_reg;
	logic [3:0] rise_cnt_reg;
	logic [CFG_BITS-1:0] cfg_shift_reg;
	cfg_t cfg_hold_reg;
	logic cfg_tog_reg;

	// a high chip select ends the frame and clears the counters
	assign frame_rst = rst_i | cs_n_i;
	assign fall_next = fall_cnt_reg + CNT_ONE;
	assign bit_idx = EOC_INDEX - fall_next;
	assign at_start = (fall_cnt_reg == '0);
	assign at_end = (fall_cnt_reg == LAST_FALL);

	always_ff @(negedge sck_i or posedge frame_rst)
		if (frame_rst)
		begin
			fall_cnt_reg <= '0;
			bit_reg <= 1'h0;
		end
		else if (!at_end)
		begin
			fall_cnt_reg <= fall_next;
			bit_reg <= word_i[bit_idx[4:0]];
		end

	// 32nd falling edge closes the data output state
	always_ff @(negedge sck_i or posedge rst_i)
		if (rst_i)
			done_tog_reg <= 1'h0;
		else if (!at_end && fall_next == LAST_FALL)
			done_tog_reg <= ~done_tog_reg;

	// first bit is the live conversion status, the last is forced high
	assign sdo_o = at_start ? eoc_n_i : (at_end ? 1'h1 : bit_reg);
	assign sdo_oe_o = ~cs_n_i;

	always_ff @(posedge sck_i or posedge frame_rst)
		if (frame_rst)
		begin
			rise_cnt_reg <= '0;
			cfg_shift_reg <= '0;
		end
		else if (rise_cnt_reg != CFG_RISES)
		begin
			rise_cnt_reg <= rise_cnt_reg + 4'h1;
			cfg_shift_reg <= {cfg_shift_reg[CFG_BITS-2:0], sdi_i};
		end

	// completed word is held outside the frame reset for the system side
	always_ff @(posedge sck_i or posedge rst_i)
		if (rst_i)
		begin
			cfg_hold_reg <= CFG_RESET;
			cfg_tog_reg <= 1'h0;
		end
		else if (!cs_n_i && rise_cnt_reg == CFG_LAST_RISE)
		begin
			cfg_hold_reg <= {cfg_shift_reg[CFG_BITS-2:0], sdi_i};
			cfg_tog_reg <= ~cfg_tog_reg;
		end

	assign frame_done_tog_o = done_tog_reg;
	assign cfg_hold_o = cfg_hold_reg;
	assign cfg_tog_o = cfg_tog_reg;
endmodule
`default_nettype wire

// ===== verif/adc_cycle_serial_readout_assertions.sv
// concurrent checks of the conversion cycle and serial readout, with their bind
`timescale 1ns/10ps
`default_nettype none
module adc_cycle_serial_readout_assertions
	import adc_cycle_pkg::*;
#(
	parameter int POR_CYCLES = 20
)
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// pins
	input wire logic cs_n_i,
	input wire logic clock_source_select_i,
	input wire logic sck_o,
	input wire logic sck_oe_o,
	input wire logic sdo_o,
	input wire logic sdo_oe_o,
	// status and configuration
	input wire logic busy_o,
	input wire state_t cycle_state_o,
	input wire logic [4:0] fe_chan_o,
	input wire logic [3:0] fe_osr_o,
	input wire logic fe_twox_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	int por_cnt;
	logic [5:0] rise_cnt;
	logic sck_q;
	wire por_hold = por_cnt < POR_CYCLES;
	// cycles since reset, and internal sck rises within one output state
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			por_cnt <= 0;
			rise_cnt <= 6'h00;
			sck_q <= 1'b0;
		end
		else
		begin
			por_cnt <= por_hold ? por_cnt + 1 : por_cnt;
			rise_cnt <= (cycle_state_o == ST_CONVERT) ? 6'h00 : rise_cnt + 6'(sck_o && !sck_q);
			sck_q <= sck_o;
		end
	end
	AST_SDO_ENABLE: assert property (sdo_oe_o == !cs_n_i) else $error("sdo enable wrong");
	AST_CYCLE_ORDER: assert property ($changed(cycle_state_o) |-> cycle_state_o ==
		{$past(cycle_state_o[1:0]), $past(cycle_state_o[2])}) else $error("state order");
	AST_SLEEP_DESELECTED: assert property ((cycle_state_o == ST_SLEEP && cs_n_i && $past(cs_n_i)
		&& $past(cs_n_i, 2) && $past(cs_n_i, 3)) |=> cycle_state_o == ST_SLEEP)
		else $error("sleep left while deselected");
	AST_EOC_ON_SDO: assert property ((!cs_n_i && cycle_state_o != ST_OUTPUT
		&& $past(cycle_state_o) != ST_OUTPUT) |-> sdo_o == busy_o)
		else $error("sdo not conversion status");
	AST_BUSY_RISE: assert property ($rose(busy_o) |-> $past(cycle_state_o, 2) == ST_OUTPUT)
		else $error("busy rose without output end");
	AST_BUSY_FALL: assert property ($fell(busy_o) |-> ##[0:1] cycle_state_o == ST_SLEEP)
		else $error("busy fell outside conversion end");
	AST_QUIET_STATES: assert property ((cycle_state_o != ST_CONVERT
		&& $past(cycle_state_o) != ST_CONVERT) |-> !busy_o) else $error("busy high");
	AST_OUTPUT_ABORT: assert property ((cycle_state_o == ST_OUTPUT && cs_n_i && $past(cs_n_i))
		|-> ##[0:4] cycle_state_o == ST_CONVERT) else $error("abort missed");
	AST_CLOCK_SOURCE: assert property ($stable(clock_source_select_i) [*5]
		|-> sck_oe_o == clock_source_select_i) else $error("sck enable wrong");
	AST_SCK_PULSES: assert property (rise_cnt <= 6'h20) else $error("too many sck");
	AST_SCK_IDLE: assert property ((cycle_state_o != ST_OUTPUT && $past(cycle_state_o) != ST_OUTPUT
		&& $past(cycle_state_o, 2) != ST_OUTPUT) |-> !sck_o) else $error("sck not idle");
	AST_POWER_ON_HOLD: assert property (por_hold |-> busy_o && cycle_state_o == ST_CONVERT)
		else $error("power-on hold broken");
	AST_POWER_ON_CONFIG: assert property (por_hold |-> fe_chan_o == 5'h00 && fe_osr_o == 4'h3
		&& !fe_twox_o) else $error("power-on configuration wrong");
	COV_ABORT: cover property (cycle_state_o == ST_OUTPUT && cs_n_i);
	COV_INTERNAL: cover property ($rose(sck_oe_o));
	COV_OUTPUT: cover property ($rose(cycle_state_o == ST_OUTPUT));
endmodule
bind adc_cycle_serial_readout adc_cycle_serial_readout_assertions #(.POR_CYCLES(POR_CYCLES)) u_chk
(
	.clock_i(clock_i),
	.rst_i(rst_i),
	.cs_n_i(cs_n_i),
	.clock_source_select_i(clock_source_select_i),
	.sck_o(sck_o),
	.sck_oe_o(sck_oe_o),
	.sdo_o(sdo_o),
	.sdo_oe_o(sdo_oe_o),
	.busy_o(busy_o),
	.cycle_state_o(cycle_state_o),
	.fe_chan_o(fe_chan_o),
	.fe_osr_o(fe_osr_o),
	.fe_twox_o(fe_twox_o)
);
`default_nettype wire

// ===== verif/adc_cycle_serial_readout_tb_top.sv
// self-checking bench of the conversion-cycle controller and serial readout
`timescale 1ns/10ps
`default_nettype none
module adc_cycle_serial_readout_tb_top
	import adc_cycle_pkg::*;
;
	typedef struct {logic [29:0] s; logic [31:0] w;} row_t;
	row_t rows[7] = '{'{30'h0000_0000, 32'h2000_0000}, '{30'h1000_0000, 32'h3000_0000},
		'{30'h1000_0001, 32'h3000_0020}, '{30'h3FFF_FFE0, 32'h1FFF_FFE0},
		'{30'h3000_0000, 32'h1000_0000}, '{30'h2FFF_FFFF, 32'h0FFF_FFE0},
		'{30'h0555_5555, 32'h2555_5555}};
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic clock_source_select_i = 1'b0;
	logic signed [CODE_W-1:0] fe_sample = '0;
	logic [29:0] sample_val;
	wire cs_n;
	wire host_sck;
	wire sdi;
	logic sck_o;
	logic sck_oe_o;
	logic sdo_o;
	logic sdo_oe_o;
	logic busy_o;
	state_t cycle_state_o;
	fe_phase_t fe_phase_o;
	logic [4:0] fe_chan_o;
	logic [3:0] fe_osr_o;
	logic fe_twox_o;
	logic [31:0] w;
	logic [1:0] fl;
	int err_total = 0;
	int compares = 0;
	int cyc = 0;
	int i;
	wire sck_line = sck_oe_o ? sck_o : host_sck;
	wire sdo_line = sdo_oe_o ? sdo_o : 1'bz;
	adc_cycle_serial_readout #(.POR_CYCLES(20), .CAL_CYCLES(4), .SAMPLE_CYCLES_OSR64(4),
		.SCK_HALF_CYCLES(2)) dut (.clock_i(clock_i), .rst_i(rst_i), .cs_n_i(cs_n),
		.clock_source_select_i(clock_source_select_i), .sck_i(sck_line), .sck_o(sck_o),
		.sck_oe_o(sck_oe_o), .sdi_i(sdi), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .busy_o(busy_o),
		.cycle_state_o(cycle_state_o), .fe_phase_o(fe_phase_o), .fe_chan_o(fe_chan_o),
		.fe_osr_o(fe_osr_o), .fe_twox_o(fe_twox_o), .fe_sample_i(fe_sample));
	adc_host_model host (.cs_n_o(cs_n), .sck_o(host_sck), .sdi_o(sdi), .sck_line_i(sck_line),
		.sdo_i(sdo_line));
	always #2.5 clock_i = ~clock_i;
	// front end: zero reads 0, reference reads full scale, input reads the test value
	always_ff @(posedge clock_i)
		fe_sample <= (fe_phase_o == PH_ZERO) ? '0 : (fe_phase_o == PH_REF) ? FS_CODE : sample_val;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wait_busy(input logic lvl);
		int n;
		for (n = 0; n < 400 && busy_o !== lvl; n++)
			@(negedge clock_i);
		chk(32'(busy_o), 32'(lvl));
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clock_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			tally_and_finish();
		end
	end
	initial
	begin
		sample_val = rows[0].s;
		repeat (3) @(negedge clock_i);
		chk(32'(busy_o), 32'h1);
		chk(32'(cycle_state_o), 32'(ST_CONVERT));
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		@(negedge clock_i);
		chk(32'({fe_chan_o, fe_osr_o, fe_twox_o}), 32'({5'h00, 4'h3, 1'b0}));
		$display("test reset done");
		for (i = 0; i < 7; i++)
		begin
			@(posedge clock_i) sample_val <= rows[i].s;
			wait_busy(1'b1);
			host.frame(1'b0, 11'h000, 32, w, fl);
			chk(w, rows[i].w);
			chk(32'(fl), 32'h3);
		end
		$display("test word table done");
		wait_busy(1'b0);
		host.pulses(6);
		chk(32'(sdo_line === 1'bz), 32'h1);
		repeat (100) @(negedge clock_i);
		chk(32'(cycle_state_o), 32'(ST_SLEEP));
		host.frame(1'b0, 11'h000, 32, w, fl);
		chk(w, rows[6].w);
		$display("test sleep hold done");
		wait_busy(1'b1);
		host.frame(1'b0, 11'h7FF, 10, w, fl);
		chk(w, 32'h0000_0095);
		wait_busy(1'b1);
		repeat (2) @(negedge clock_i);
		chk(32'(fe_chan_o), 32'h0);
		$display("test abort done");
		host.frame(1'b0, {1'b1, 5'h05, 4'h1, 1'b0}, 32, w, fl);
		chk(w, rows[6].w);
		wait_busy(1'b1);
		repeat (2) @(negedge clock_i);
		chk(32'({fe_chan_o, fe_osr_o}), 32'({5'h05, 4'h1}));
		host.frame(1'b0, {1'b0, 5'h1A, 4'h7, 1'b0}, 32, w, fl);
		wait_busy(1'b1);
		repeat (2) @(negedge clock_i);
		chk(32'({fe_chan_o, fe_osr_o}), 32'({5'h05, 4'h1}));
		$display("test configuration done");
		// 2X mode: each word carries the result of the conversion before it
		host.frame(1'b0, {1'b1, 5'h05, 4'h1, 1'b1}, 32, w, fl);
		chk(w, rows[6].w);
		@(posedge clock_i) sample_val <= rows[1].s;
		wait_busy(1'b1);
		repeat (2) @(negedge clock_i);
		chk(32'(fe_twox_o), 32'h1);
		host.frame(1'b0, 11'h000, 32, w, fl);
		chk(w, rows[6].w);
		wait_busy(1'b1);
		host.frame(1'b0, 11'h000, 32, w, fl);
		chk(w, rows[1].w);
		$display("test 2X latency done");
		@(posedge clock_i) clock_source_select_i <= 1'b1;
		repeat (6) @(negedge clock_i);
		chk(32'(sck_oe_o), 32'h1);
		host.frame(1'b1, 11'h000, 32, w, fl);
		chk(w, rows[1].w);
		chk(32'(fl[0]), 32'h1);
		$display("test internal clock done");
		tally_and_finish();
	end
endmodule
`default_nettype wire

// ===== verif/adc_host_model.sv
// host model: chip select, serial clock and configuration data
`timescale 1ns/10ps
`default_nettype none
module adc_host_model
(
	// pins towards the converter
	output logic cs_n_o,
	output logic sck_o,
	output logic sdi_o,
	input wire logic sck_line_i,
	input wire logic sdo_i
);
	initial
	begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		sdi_o = 1'b0;
	end
	// stray pulses while deselected
	task automatic pulses(input int n);
		repeat (n)
		begin
			#7.5 sck_o = 1'b1;
			#7.5 sck_o = 1'b0;
		end
	endtask
	// fl[1]: status seen high at select, fl[0]: level after the last fall
	task automatic frame(input logic intl, input logic [10:0] cfg, input int nfall,
		output logic [31:0] w, output logic [1:0] fl);
		int t;
		w = 32'h0000_0000;
		cs_n_o = 1'b0;
		sdi_o = cfg[10];
		#1 fl[1] = sdo_i;
		// clock only once conversion is done
		for (t = 0; t < 4000 && sdo_i !== 1'b0; t++)
			#1;
		if (!intl)
			#30;
		for (t = 0; t < nfall; t++)
		begin
			if (intl)
				@(posedge sck_line_i);
			else
				sck_o = 1'b1;
			w = {w[30:0], sdo_i};
			if (intl)
				@(negedge sck_line_i);
			else
				#7.5 sck_o = 1'b0;
			if (t < 10)
				sdi_o = cfg[9-t];
			if (!intl)
				#7.5;
		end
		#2 fl[0] = sdo_i;
		cs_n_o = 1'b1;
		sdi_o = ~sdi_o;
	endtask
endmodule
`default_nettype wire
